// ---- fpv_panel.sv ----
// Purpose: front panel value entry, display, LEDs and run control
// Assumes: keys [3:0] arrows (3 leftmost), 4 diam, 5 rate, 6 vol, 7 dir, 8 start
// Notes:   AHB-Lite slave, zero wait states, always OKAY
`timescale 1ns/1ns
`default_nettype none
`include "fpv_cfg.svh"
module fpv_panel
  import fpv_pkg::*;
#(
  parameter int TICK_CYCLES = `FPV_CLK_HZ / 1000 * `FPV_TICK_MS
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [8:0]  key_raw,
  input  wire logic        stall_clamp,
  input  wire logic        pause_phase,
  input  wire logic        rx_ok,
  output logic             motor_run,
  output logic             prog_begin,
  output logic             prog_resume,
  output logic             buzzer,
  output logic             nv_write,
  output logic      [17:0] nv_data,
  output fpv_disp_type     disp,
  output logic      [7:0]  leds
);
  localparam int COMMIT_T = `FPV_COMMIT_MS / `FPV_TICK_MS;
  localparam int HOLD_T   = `FPV_HOLD_MS / `FPV_TICK_MS;
  localparam int REPEAT_T = `FPV_REPEAT_MS / `FPV_TICK_MS;
  localparam int BLINK_T  = `FPV_BLINK_MS / `FPV_TICK_MS;
  if (COMMIT_T > 255 || HOLD_T > 255 || REPEAT_T < 1) begin : g_chk
    $error("fpv_panel: tick counts do not fit");
  end

  // ----------------------------------------
  // timing sources and keys
  // ----------------------------------------
  logic       tick;
  logic       blink;
  logic [8:0] key_level;
  logic [8:0] key_press;

  fpv_prescale #(.CYCLES(TICK_CYCLES), .BLINK(BLINK_T)) u_pre
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick),
    .blink   (blink)
  );

  fpv_debounce #(.N(9), .TICKS(`FPV_DEB_TICKS)) u_deb
  (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .tick      (tick),
    .key_raw   (key_raw),
    .key_level (key_level),
    .key_press (key_press)
  );

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  logic        d_wr;
  logic [7:0]  d_addr;
  logic [6:0]  ctrl;
  logic [15:0] value;
  logic [1:0]  dp;
  logic [31:0] limit;
  logic [4:0]  unit_mask;
  logic [1:0]  rate_unit;
  logic        stall_flag;
  fpv_prog_type prog;
  fpv_edit_type edit;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // address phase capture; read data ready for the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      d_wr   <= 1'b0;
      d_addr <= 8'h00;
      hrdata <= 32'h0;
    end
    else if (hready)
    begin
      d_wr   <= hsel & htrans[1] & hwrite;
      d_addr <= haddr;
      hrdata <= 32'h0;
      if (hsel && htrans[1] && !hwrite)
      begin
        unique case (haddr)
          `FPV_CTRL:   hrdata <= {25'h0, ctrl};
          `FPV_VALUE:  hrdata <= {14'h0, dp, value};
          `FPV_LIMIT:  hrdata <= limit;
          `FPV_UNITS:  hrdata <= {25'h0, rate_unit, unit_mask};
          `FPV_STATUS: hrdata <= {27'h0, stall_flag, edit, prog};
          default:     hrdata <= 32'h0;
        endcase
      end
    end
  end

  logic wr_ctrl;
  logic wr_value;
  logic wr_limit;
  logic wr_units;
  logic wr_status;
  assign wr_ctrl   = d_wr && d_addr == `FPV_CTRL;
  assign wr_value  = d_wr && d_addr == `FPV_VALUE;
  assign wr_limit  = d_wr && d_addr == `FPV_LIMIT;
  assign wr_units  = d_wr && d_addr == `FPV_UNITS;
  assign wr_status = d_wr && d_addr == `FPV_STATUS;

  logic [1:0] kind;
  logic       running;
  assign kind    = ctrl[`FPV_C_KIND +: 2];
  assign running = prog == FPV_RUN;

  // control word; direction key flips direction while stopped
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl <= `FPV_CTRL_RST;
    else if (wr_ctrl)
      ctrl <= hwdata[6:0];
    else if (key_press[7] && prog == FPV_STOP && edit != FPV_ERR)
      ctrl[`FPV_C_WDRAW] <= ~ctrl[`FPV_C_WDRAW];
  end

  // validation limits, bcd min low, max high
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      limit <= `FPV_LIMIT_RST;
    else if (wr_limit)
      limit <= hwdata;
  end

  // ----------------------------------------
  // arrow stepping, repeat and point mode
  // ----------------------------------------
  logic [7:0] rep_cnt;
  logic [7:0] hold_cnt;
  logic [7:0] idle_cnt;
  logic       dp_mode;
  logic [3:0] step;
  logic [15:0] inc;
  logic        any_arrow;
  logic        other_press;
  logic        rep_fire;
  logic        wrap3;
  assign any_arrow   = |key_level[3:0];
  assign other_press = |key_press[8:4];
  assign rep_fire    = tick && rep_cnt == 8'(REPEAT_T - 1);

  // each arrow steps on press and on repeat while held
  assign step = key_press[3:0] | ({4{rep_fire}} & key_level[3:0]);

  genvar g;
  for (g = 0; g < 4; g++) begin : g_dig
    assign inc[g*4 +: 4] = (value[g*4 +: 4] >= 4'h9) ? 4'h0
                           : value[g*4 +: 4] + 4'h1;
  end
  assign wrap3 = step[3] && value[15:12] == 4'h9 && kind == 2'h0;

  // repeat interval counter, restarts while no arrow held
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rep_cnt <= 8'h0;
    else if (!any_arrow || rep_fire)
      rep_cnt <= 8'h0;
    else if (tick)
      rep_cnt <= rep_cnt + 8'h1;
  end

  // leftmost hold time and point shift mode
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hold_cnt <= 8'h0;
      dp_mode  <= 1'b0;
    end
    else if (!key_level[3])
    begin
      hold_cnt <= 8'h0;
      dp_mode  <= 1'b0;
    end
    else
    begin
      if (tick && hold_cnt != 8'(HOLD_T))
        hold_cnt <= hold_cnt + 8'h1;
      if (hold_cnt == 8'(HOLD_T) && wrap3)
        dp_mode <= 1'b1;
    end
  end

  // ----------------------------------------
  // edit state, commit and error
  // ----------------------------------------
  logic [19:0] orig;
  logic        do_commit;
  logic        valid;
  logic        changed;
  logic        editing;
  assign editing   = edit == FPV_EDIT;
  assign do_commit = editing && (other_press
                     || (tick && idle_cnt == 8'(COMMIT_T - 1)));
  // only free digit entry can leave its limits; stepped kinds wrap
  assign valid   = kind != 2'h0 || (value >= limit[15:0] && value <= limit[31:16]);
  assign changed = {value, dp, rate_unit} != orig;

  // idle time since the last arrow step
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      idle_cnt <= 8'h0;
    else if (|step || !editing)
      idle_cnt <= 8'h0;
    else if (tick)
      idle_cnt <= idle_cnt + 8'h1;
  end

  // edit sequencing: first step opens an edit, commit closes it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      edit <= FPV_IDLE;
      orig <= 20'h0;
    end
    else
    begin
      unique case (edit)
        FPV_IDLE:
          if (|step)
          begin
            edit <= FPV_EDIT;
            orig <= {value, dp, rate_unit};
          end
        FPV_EDIT:
          if (do_commit)
            edit <= valid ? FPV_IDLE : FPV_ERR;
        FPV_ERR:
          if (|key_press)
            edit <= FPV_IDLE;
      endcase
    end
  end

  // value and point; stepping by kind, restore on error clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      value <= 16'h0;
      dp    <= `FPV_DP_WHOLE;
    end
    else if (edit == FPV_ERR)
    begin
      if (|key_press)
      begin
        value <= orig[19:4];
        dp    <= orig[3:2];
      end
    end
    else if (wr_value)
    begin
      value <= hwdata[15:0];
      dp    <= hwdata[17:16];
    end
    else if (kind == 2'h0)
    begin
      if (dp_mode && step[3])
        dp <= dp + 2'h1;
      for (int i = 0; i < 4; i++)
        if (step[i] && !(i == 3 && dp_mode))
          value[i*4 +: 4] <= inc[i*4 +: 4];
    end
    else if (kind == 2'h1 && |step)
      value <= (value >= limit[31:16]) ? limit[15:0]
               : value + 16'h1;
  end

  // unit mask and rate unit combination
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      unit_mask <= 5'h0;
      rate_unit <= 2'h0;
    end
    else if (edit == FPV_ERR && |key_press)
      rate_unit <= orig[1:0];
    else if (wr_units)
    begin
      unit_mask <= hwdata[4:0];
      rate_unit <= hwdata[6:5];
    end
    else if (kind == 2'h2 && |step && edit != FPV_ERR)
      rate_unit <= rate_unit + 2'h1;
  end

  // storage write: panel commits, and link writes unless in error or rate while running
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      nv_write <= 1'b0;
      nv_data  <= 18'h0;
    end
    else
    begin
      nv_write <= 1'b0;
      if (do_commit && valid && changed)
      begin
        nv_write <= 1'b1;
        nv_data  <= {dp, value};
      end
      else if (wr_value && edit != FPV_ERR && !(ctrl[`FPV_C_RATE] && running))
      begin
        nv_write <= 1'b1;
        nv_data  <= hwdata[17:0];
      end
    end
  end

  // ----------------------------------------
  // program run control and stall alarm
  // ----------------------------------------
  logic stall_hit;
  assign stall_hit = running && stall_clamp && !ctrl[`FPV_C_WDRAW];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prog        <= FPV_STOP;
      prog_begin  <= 1'b0;
      prog_resume <= 1'b0;
    end
    else
    begin
      prog_begin  <= 1'b0;
      prog_resume <= 1'b0;
      unique case (prog)
        FPV_STOP:
          if (key_press[8] && edit != FPV_ERR)
          begin
            prog       <= FPV_RUN;
            prog_begin <= 1'b1;
          end
        FPV_RUN:
          if (stall_hit || key_press[8])
            prog <= FPV_PAUSE;
        FPV_PAUSE:
          if (key_press[8])
          begin
            prog        <= FPV_RUN;
            prog_resume <= 1'b1;
          end
          else if (|key_press[7:0])
            prog <= FPV_STOP;
        default:
          prog <= FPV_STOP;
      endcase
    end
  end

  // stall flag: set wins over a software clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      stall_flag <= 1'b0;
    else if (stall_hit)
      stall_flag <= 1'b1;
    else if (wr_status && hwdata[`FPV_S_STALL])
      stall_flag <= 1'b0;
  end

  assign motor_run = running && !pause_phase;
  assign buzzer    = stall_flag && ctrl[`FPV_C_ALARM];

  // ----------------------------------------
  // display and LEDs
  // ----------------------------------------
  logic [3:0] flash_cnt;
  logic [3:0] rx_cnt;
  logic       blink_q;
  logic [4:0] units;

  // commit flash and receive mark, counted in blink edges
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      flash_cnt <= 4'h0;
      rx_cnt    <= 4'h0;
      blink_q   <= 1'b0;
    end
    else
    begin
      blink_q <= blink;
      if (do_commit && valid && changed)
        flash_cnt <= 4'(`FPV_FLASH_N);
      else if (blink != blink_q && flash_cnt != 4'h0)
        flash_cnt <= flash_cnt - 4'h1;
      if (rx_ok)
        rx_cnt <= 4'h2;
      else if (blink != blink_q && rx_cnt != 4'h0)
        rx_cnt <= rx_cnt - 4'h1;
    end
  end

  // rate combos: ml/min, ml/hr, ul/min, ul/hr as mm,ml,min,ul,hr bits
  always_comb
  begin
    units = unit_mask;
    if (kind == 2'h2)
      units = {1'b0, ~rate_unit[1], ~rate_unit[0], rate_unit[1], rate_unit[0]};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      disp <= '0;
      leds <= 8'h0;
    end
    else
    begin
      disp.digits  <= value;
      disp.dp      <= dp;
      disp.dp_on   <= dp != `FPV_DP_WHOLE;
      disp.colon   <= ctrl[`FPV_C_COLON];
      disp.rx_mark <= rx_cnt != 4'h0;
      disp.blank   <= flash_cnt != 4'h0 && blink;
      disp.error   <= edit == FPV_ERR;
      leds[4:0]    <= editing ? (units & {5{blink}}) : units;
      leds[5]      <= ctrl[`FPV_C_DISP];
      leds[6]      <= ctrl[`FPV_C_WDRAW];
      leds[7]      <= motor_run || (prog == FPV_PAUSE && blink);
    end
  end
endmodule
`default_nettype wire

// ---- fpv_cfg.svh ----
// Purpose: constants for the front panel value entry block
// Assumes: 50 MHz hclk, byte offsets on AHB-Lite
// Notes:   timing counts are derived in the modules from these figures
`ifndef FPV_CFG_SVH
`define FPV_CFG_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define FPV_CLK_HZ    50000000
`define FPV_TICK_MS   10
`define FPV_COMMIT_MS 2000
`define FPV_HOLD_MS   1000
`define FPV_REPEAT_MS 200
`define FPV_BLINK_MS  250
`define FPV_DEB_TICKS 2
`define FPV_FLASH_N   4

// ----------------------------------------
// register offsets and fields
// ----------------------------------------
`define FPV_CTRL   8'h00
`define FPV_VALUE  8'h04
`define FPV_LIMIT  8'h08
`define FPV_UNITS  8'h0c
`define FPV_STATUS 8'h10
`define FPV_C_ALARM 0
`define FPV_C_WDRAW 1
`define FPV_C_DISP  2
`define FPV_C_COLON 3
`define FPV_C_KIND  4
`define FPV_C_RATE  6
`define FPV_S_STALL 4
`define FPV_CTRL_RST  7'h00
`define FPV_LIMIT_RST 32'h9999_0000
`define FPV_DP_WHOLE  2'h3
`endif

// ---- fpv_pkg.sv ----
// Purpose: types for the front panel value entry block
// Assumes: nothing
// Notes:   constants live in fpv_cfg.svh
package fpv_pkg;
  typedef enum logic [1:0] {FPV_STOP, FPV_RUN, FPV_PAUSE} fpv_prog_type;
  typedef enum logic [1:0] {FPV_IDLE, FPV_EDIT, FPV_ERR} fpv_edit_type;
  typedef struct packed {
    logic [15:0] digits;
    logic [1:0]  dp;
    logic        dp_on;
    logic        colon;
    logic        rx_mark;
    logic        blank;
    logic        error;
  } fpv_disp_type;
endpackage

// ---- fpv_prescale.sv ----
// Purpose: tick prescaler and blink phase
// Assumes: CYCLES >= 2
// Notes:   one tick source for every panel timer
`timescale 1ns/1ns
`default_nettype none
module fpv_prescale
#(
  parameter int CYCLES = 500000,
  parameter int BLINK  = 25
)
(
  input  wire logic hclk,
  input  wire logic hresetn,
  output logic      tick,
  output logic      blink
);
  if (CYCLES < 2 || BLINK < 1) begin : g_chk
    $error("fpv_prescale: bad counts");
  end
  logic [$clog2(CYCLES)-1:0] cnt;
  logic [$clog2(BLINK+1)-1:0] bcnt;

  // cycle divider, tick is one cycle wide
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt  <= '0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= (cnt == $bits(cnt)'(CYCLES - 1));
      cnt  <= (cnt == $bits(cnt)'(CYCLES - 1)) ? '0 : cnt + 1'b1;
    end
  end

  // blink half period in ticks
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bcnt  <= '0;
      blink <= 1'b0;
    end
    else if (tick)
    begin
      if (bcnt == $bits(bcnt)'(BLINK - 1))
      begin
        bcnt  <= '0;
        blink <= ~blink;
      end
      else
        bcnt <= bcnt + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- fpv_debounce.sv ----
// Purpose: key synchroniser and debouncer
// Assumes: keys active high
// Notes:   a level must stay stable for TICKS ticks to be accepted
`timescale 1ns/1ns
`default_nettype none
module fpv_debounce
#(
  parameter int N     = 9,
  parameter int TICKS = 2
)
(
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         tick,
  input  wire logic [N-1:0] key_raw,
  output logic      [N-1:0] key_level,
  output logic      [N-1:0] key_press
);
  if (N < 1 || TICKS < 1 || TICKS > 15) begin : g_chk
    $error("fpv_debounce: bad parameters");
  end
  genvar g;
  for (g = 0; g < N; g++) begin : g_key
    logic       s1;
    logic       s2;
    logic [3:0] cnt;
    // two flops; only s2 is looked at
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        s1 <= 1'b0;
        s2 <= 1'b0;
      end
      else
      begin
        s1 <= key_raw[g];
        s2 <= s1;
      end
    end
    // accept a change after stable ticks; press pulse on accepted rise
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        cnt          <= 4'h0;
        key_level[g] <= 1'b0;
        key_press[g] <= 1'b0;
      end
      else
      begin
        key_press[g] <= 1'b0;
        if (s2 == key_level[g])
          cnt <= 4'h0;
        else if (tick)
        begin
          if (cnt == 4'(TICKS - 1))
          begin
            cnt          <= 4'h0;
            key_level[g] <= s2;
            key_press[g] <= s2;
          end
          else
            cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- fpv_panel_properties.sv ----
// Purpose: concurrent checks on the panel outputs
// Assumes: one hclk domain
// Notes:   bound to fpv_panel from the bench top
`timescale 1ns/1ns
`default_nettype none
module fpv_panel_properties
  import fpv_pkg::*;
(
  input wire logic         hclk,
  input wire logic         hresetn,
  input wire logic         stall_clamp,
  input wire logic         rx_ok,
  input wire logic         motor_run,
  input wire logic         prog_begin,
  input wire logic         prog_resume,
  input wire logic         nv_write,
  input wire fpv_disp_type disp,
  input wire logic [7:0]   leds
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----
  // run control
  // ----
  property p_stall_stop;
    motor_run && stall_clamp && !leds[6] |=> !motor_run;
  endproperty
  a_stall_stop: assert property (p_stall_stop) else $error("motor ran on at clamp");
  // led register may lag the motor by up to two cycles
  property p_run_led;
    motor_run [*3] |-> leds[7];
  endproperty
  a_run_led: assert property (p_run_led) else $error("pumping led dark while running");
  property p_begin_pulse;
    prog_begin |-> !prog_resume ##1 !prog_begin;
  endproperty
  a_begin_pulse: assert property (p_begin_pulse) else $error("begin pulse malformed");
  property p_resume_pulse;
    prog_resume |=> !prog_resume && !prog_begin;
  endproperty
  a_resume_pulse: assert property (p_resume_pulse) else $error("resume pulse malformed");
  // ----
  // display and leds
  // ----
  property p_rx_mark;
    rx_ok |-> ##[1:3] disp.rx_mark;
  endproperty
  a_rx_mark: assert property (p_rx_mark) else $error("receive mark not lit");
  property p_dp_hidden;
    disp.dp == 2'h3 |-> !disp.dp_on;
  endproperty
  a_dp_hidden: assert property (p_dp_hidden) else $error("whole number point shown");
  property p_two_units;
    $countones(leds[4:0]) <= 2;
  endproperty
  a_two_units: assert property (p_two_units) else $error("more than two unit leds");
  property p_err_no_store;
    disp.error |-> !nv_write;
  endproperty
  a_err_no_store: assert property (p_err_no_store) else $error("stored during error");
endmodule
`default_nettype wire

// ---- fpv_keypad.sv ----
// Purpose: operator keypad model
// Assumes: a closed key reads high, an open key low
// Notes:   every press chatters before settling
`timescale 1ns/1ns
`default_nettype none
module fpv_keypad
(
  input  wire logic       hclk,
  output logic      [8:0] key_raw
);
  initial key_raw = 9'h000;
  // chatter is shorter than the debounce span, so one press stays one step
  task automatic tap(input int k, input int hold);
    @(posedge hclk) key_raw[k] <= 1'h1;
    @(posedge hclk) key_raw[k] <= 1'h0;
    @(posedge hclk) key_raw[k] <= 1'h1;
    repeat (hold) @(posedge hclk);
    key_raw[k] <= 1'h0;
    // open long enough for the release to be seen before the next press
    repeat (60) @(posedge hclk);
  endtask
endmodule
`default_nettype wire

// ---- fpv_panel_tb.sv ----
// Purpose: self-checking bench for fpv_panel
// Assumes: tick cut to 10 clocks: commit 2000, hold 1000, repeat 200
// Notes:   keypad model presses keys; bench drives bus and sequencer
`timescale 1ns/1ns
`default_nettype none
module fpv_panel_tb
  import fpv_pkg::*;
();
  logic         hclk, hresetn, hsel, hwrite, stall_clamp, pause_phase, rx_ok;
  logic         hreadyout, hresp, motor_run, prog_begin, prog_resume, buzzer, nv_write;
  logic [7:0]   haddr, leds;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [31:0]  hwdata, hrdata, rd;
  logic [17:0]  nv_data;
  logic [8:0]   key_raw;
  fpv_disp_type disp;
  wire          hready = hreadyout;
  int           n_mismatch, total_checks, n_nv, n_begin, n_resume, n_blank, b0, k;

  fpv_panel #(.TICK_CYCLES(10)) dut_u (.*);
  fpv_keypad kp_u (.hclk(hclk), .key_raw(key_raw));

  initial
  begin
    hclk = 1'h0;
    forever #10 hclk = ~hclk;
  end

  // tallies, so one-cycle pulses are never missed between checks
  always @(posedge hclk)
  begin
    n_nv <= n_nv + int'(nv_write);
    n_begin <= n_begin + int'(prog_begin);
    n_resume <= n_resume + int'(prog_resume);
    n_blank <= n_blank + int'(disp.blank);
  end

  // ----
  // tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one single transfer; read data taken at the data phase edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    do @(posedge hclk); while (hready !== 1'h1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
    repeat (3) @(posedge hclk);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    chk(nm, exp, rd);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // hang guard, well above the roughly 11000 cycles of the sequence
  initial
  begin
    repeat (40000) @(posedge hclk);
    n_mismatch++;
    complete_run;
  end

  // ----
  // sequence
  // ----
  initial
  begin
    hresetn = 1'h0;
    {hsel, hwrite, stall_clamp, pause_phase, rx_ok} = 5'h00;
    haddr = 8'h00;
    htrans = 2'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    // reset values and an unmapped place
    wr(8'h20, 32'hffff_ffff);
    rchk("unmapped", 8'h20, 32'h0);
    rchk("ctrl", 8'h00, 32'h0);
    rchk("limit", 8'h08, 32'h9999_0000);
    rchk("value", 8'h04, 32'h0003_0000);
    chk("dp shown", 32'h0, disp.dp_on);
    chk("bus okay", 32'h2, {hreadyout, hresp});
    // a link write is stored; one tap wraps 9 to 0; commit after the quiet span
    wr(8'h04, 32'h0003_0009);
    chk("link store", 32'h1, n_nv);
    kp_u.tap(0, 50);
    repeat (1700) @(posedge hclk);
    rchk("editing", 8'h10, 32'h4);
    rchk("wrapped", 8'h04, 32'h0003_0000);
    b0 = n_blank;
    repeat (400) @(posedge hclk);
    rchk("committed", 8'h10, 32'h0);
    chk("stores", 32'h2, n_nv);
    chk("stored data", 32'h0003_0000, nv_data);
    repeat (600) @(posedge hclk);
    chk("display blink", 32'h1, 32'(n_blank > b0));
    // above the limit: error on a non-arrow key, next key restores
    wr(8'h08, 32'h0005_0000);
    wr(8'h04, 32'h0003_0004);
    kp_u.tap(0, 50);
    kp_u.tap(0, 50);
    kp_u.tap(6, 50);
    rchk("error state", 8'h10, 32'h8);
    chk("error shown", 32'h1, disp.error);
    kp_u.tap(6, 50);
    rchk("restored", 8'h04, 32'h0003_0004);
    rchk("error cleared", 8'h10, 32'h0);
    chk("no store", 32'h3, n_nv);
    // hold leftmost: ten steps wrap the digit, three more move the point
    wr(8'h08, 32'h9999_0000);
    wr(8'h04, 32'h0003_0000);
    kp_u.tap(3, 2500);
    rchk("point moved", 8'h04, 32'h0002_0000);
    repeat (2200) @(posedge hclk);
    chk("point pos", 32'h2, disp.dp);
    chk("point on", 32'h1, disp.dp_on);
    chk("digits", 32'h0, disp.digits);
    // direction and dispensed indicators, colon, receive mark
    wr(8'h00, 32'h0000_000e);
    chk("dir disp leds", 32'h3, leds[6:5]);
    chk("colon", 32'h1, disp.colon);
    rx_ok <= 1'h1;
    @(posedge hclk);
    rx_ok <= 1'h0;
    repeat (3) @(posedge hclk);
    chk("rx mark", 32'h1, disp.rx_mark);
    // run, pause phase, link rate while running, stall with alarm
    wr(8'h00, 32'h0000_0001);
    kp_u.tap(8, 50);
    chk("begin", 32'h1, n_begin);
    chk("motor", 32'h1, motor_run);
    chk("run led", 32'h1, leds[7]);
    pause_phase <= 1'h1;
    repeat (3) @(posedge hclk);
    chk("phase led", 32'h0, {motor_run, leds[7]});
    pause_phase <= 1'h0;
    wr(8'h00, 32'h0000_0041);
    wr(8'h04, 32'h0003_0123);
    chk("rate not stored", 32'h5, n_nv);
    stall_clamp <= 1'h1;
    repeat (3) @(posedge hclk);
    chk("stall motor", 32'h0, motor_run);
    chk("buzzer", 32'h1, buzzer);
    rchk("stall status", 8'h10, 32'h12);
    stall_clamp <= 1'h0;
    k = 0;
    repeat (1000)
    begin
      @(posedge hclk);
      k += int'(leds[7]);
    end
    chk("paused led", 32'h1, 32'(k > 0 && k < 1000));
    wr(8'h10, 32'h0000_0010);
    chk("buzzer off", 32'h0, buzzer);
    kp_u.tap(8, 50);
    chk("resume", 32'h1, n_resume);
    kp_u.tap(8, 50);
    kp_u.tap(6, 50);
    rchk("stopped", 8'h10, 32'h0);
    kp_u.tap(8, 50);
    chk("begin again", 32'h2, n_begin);
    // stepped kinds: a list wraps max to min, rate select advances units
    wr(8'h08, 32'h0001_0000);
    wr(8'h00, 32'h0000_0010);
    wr(8'h04, 32'h0003_0000);
    kp_u.tap(2, 50);
    rchk("list step", 8'h04, 32'h0003_0001);
    kp_u.tap(1, 50);
    rchk("list wrap", 8'h04, 32'h0003_0000);
    kp_u.tap(4, 50);
    wr(8'h0c, 32'h0000_0003);
    wr(8'h00, 32'h0000_0020);
    kp_u.tap(0, 50);
    k = 0;
    repeat (500)
    begin
      @(posedge hclk);
      k += int'(leds[4:0] == 5'h00);
    end
    chk("unit blink", 32'h1, 32'(k > 0 && k < 500));
    kp_u.tap(4, 50);
    rchk("rate unit", 8'h0c, 32'h0000_0023);
    chk("rate leds", 32'h9, leds[4:0]);
    complete_run;
  end
endmodule

bind fpv_panel fpv_panel_properties chk_u (.*);
`default_nettype wire
